// ---- clcr_pkg.sv ----
// Purpose: Shared constants for the converter link configuration register bank.
// Assumes: 24-bit serial frames: read flag, page flag, two spare bits, 12-bit address, 8-bit data.
// Notes: All fields reset to zero.
package clcr_pkg;

    localparam int ADDR_W = 12;
    localparam int DATA_W = 8;
    localparam int FRAME_W = 24;
    localparam int HDR_W = 16;

    // Frame layout; header bit 15 is the first bit shifted in
    localparam int HDR_RW_BIT = 15;
    localparam int HDR_MPAGE_BIT = 14;
    localparam logic [4:0] CNT_HDR_LAST = 5'h0f;
    localparam logic [4:0] CNT_HDR_DONE = 5'h10;
    localparam logic [4:0] CNT_DATA_LAST = 5'h17;
    localparam logic [4:0] CNT_FULL = 5'h18;

    // Register offsets
    localparam logic [ADDR_W-1:0] OFS_PAGE_SEL = 12'h012;
    localparam logic [ADDR_W-1:0] OFS_LANE_AMP = 12'h03d;
    localparam logic [ADDR_W-1:0] OFS_SOFT_REF = 12'h057;
    localparam logic [ADDR_W-1:0] OFS_SYNC_POL = 12'h058;
    localparam logic [ADDR_W-1:0] OFS_LOW_RATE_1 = 12'h03f;
    localparam logic [ADDR_W-1:0] OFS_LOW_RATE_2 = 12'h042;

    // Page codes, valid with the page flag at 0
    localparam logic [7:0] PAGE_MASTER = 8'h00;
    localparam logic [7:0] PAGE_CONV = 8'hff;

    // Field positions
    localparam int AMP_LSB = 0;
    localparam int AMP_W = 3;
    localparam int REF_SRC_BIT = 3;
    localparam int REF_LVL_BIT = 4;
    localparam int SYNC_INV_BIT = 5;
    localparam int LOW1_BIT = 2;
    localparam int LOW2_BIT = 4;

    // Reset values
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [2:0] RST_AMP = 3'h0;
    localparam logic [7:0] RST_PAGE = 8'h00;

endpackage

// ---- clcr_spi_if.sv ----
// Purpose: Carries decoded serial frames from the shifter to the register bank.
// Assumes: One clock domain, i_ref_clk.
// Notes: rdata is combinational from the bank, sampled by the shifter after hdr_done.
`timescale 1ns/1ns
interface clcr_spi_if;
    import clcr_pkg::*;
    logic hdr_done;
    logic rw;
    logic mpage;
    logic [ADDR_W-1:0] addr;
    logic wr_strobe;
    logic [DATA_W-1:0] wdata;
    logic [DATA_W-1:0] rdata;

    modport shifter (output hdr_done, output rw, output mpage, output addr, output wr_strobe,
                     output wdata, input rdata);
    modport bank (input hdr_done, input rw, input mpage, input addr, input wr_strobe,
                  input wdata, output rdata);
endinterface

// ---- clcr_spi_shifter.sv ----
// Purpose: Serial control port frame shifter, sampled on the reference clock.
// Assumes: Serial clock half period of at least four reference clock cycles.
// Notes: Data in on rising serial clock, first read bit right after the header, the rest on falling edges, MSB first.
`timescale 1ns/1ns
module clcr_spi_shifter
    import clcr_pkg::*;
(
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    input wire logic i_spi_sen_n,
    input wire logic i_spi_sclk,
    input wire logic i_spi_sdin,
    output logic o_spi_sdout,
    output logic o_spi_sdout_oe,
    clcr_spi_if.shifter bus
);

    logic [2:0] sen_s;
    logic [2:0] clk_s;
    logic [2:0] din_s;
    logic sen_f;
    logic sclk_f;
    logic [4:0] cnt;
    logic [FRAME_W-1:0] shreg;
    logic [HDR_W-1:0] hdr;
    logic [DATA_W-1:0] tx;
    logic load_pend;
    logic sclk_rise;
    logic sclk_fall;
    logic active;

    // Three-stage synchronisers; a select or clock level counts once stages two and three agree, data is taken from stage three
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            sen_s <= 3'h7;
            clk_s <= 3'h0;
            din_s <= 3'h0;
        end else begin
            sen_s <= {sen_s[1:0], i_spi_sen_n};
            clk_s <= {clk_s[1:0], i_spi_sclk};
            din_s <= {din_s[1:0], i_spi_sdin};
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            sen_f <= 1'b1;
            sclk_f <= 1'b0;
        end else begin
            if (sen_s[1] == sen_s[2]) begin
                sen_f <= sen_s[2];
            end
            if (clk_s[1] == clk_s[2]) begin
                sclk_f <= clk_s[2];
            end
        end
    end

    assign active = !sen_f;
    assign sclk_rise = (clk_s[1] == clk_s[2]) && clk_s[2] && !sclk_f && active;
    assign sclk_fall = (clk_s[1] == clk_s[2]) && !clk_s[2] && sclk_f && active;

    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cnt <= 5'h0;
            shreg <= '0;
        end else if (!active) begin
            cnt <= 5'h0;
        end else if (sclk_rise && cnt != CNT_FULL) begin
            shreg <= {shreg[FRAME_W-2:0], din_s[2]};
            cnt <= cnt + 5'h1;
        end
    end

    // Header capture and write strobe
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            hdr <= '0;
            bus.hdr_done <= 1'b0;
            bus.wr_strobe <= 1'b0;
            bus.wdata <= RST_BYTE;
        end else begin
            bus.hdr_done <= sclk_rise && cnt == CNT_HDR_LAST;
            bus.wr_strobe <= sclk_rise && cnt == CNT_DATA_LAST && !hdr[HDR_RW_BIT];
            if (sclk_rise && cnt == CNT_HDR_LAST) begin
                hdr <= {shreg[HDR_W-2:0], din_s[2]};
            end
            if (sclk_rise && cnt == CNT_DATA_LAST) begin
                bus.wdata <= {shreg[DATA_W-2:0], din_s[2]};
            end
        end
    end

    assign bus.rw = hdr[HDR_RW_BIT];
    assign bus.mpage = hdr[HDR_MPAGE_BIT];
    assign bus.addr = hdr[ADDR_W-1:0];

    // Read data out: first bit right after the header, the rest on falling edges
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            load_pend <= 1'b0;
            tx <= RST_BYTE;
            o_spi_sdout <= 1'b0;
        end else begin
            load_pend <= bus.hdr_done;
            if (load_pend) begin
                o_spi_sdout <= bus.rdata[DATA_W-1];
                tx <= {bus.rdata[DATA_W-2:0], 1'b0};
            end else if (sclk_fall && cnt > CNT_HDR_DONE && cnt != CNT_FULL) begin
                o_spi_sdout <= tx[DATA_W-1];
                tx <= {tx[DATA_W-2:0], 1'b0};
            end
        end
    end

    assign o_spi_sdout_oe = active && hdr[HDR_RW_BIT] && cnt >= CNT_HDR_DONE;

endmodule

// ---- clcr_regs.sv ----
// Purpose: Converter link configuration register bank behind the serial control port.
// Assumes: Page select register chooses master or converter page for accesses with page flag 0.
// Notes: Timing reference and sync request pins are synchronised to i_ref_clk.
`timescale 1ns/1ns

module clcr_regs
    import clcr_pkg::*;
(
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    input wire logic i_spi_sen_n,
    input wire logic i_spi_sclk,
    input wire logic i_spi_sdin,
    output logic o_spi_sdout,
    output logic o_spi_sdout_oe,
    input wire logic i_timing_reference_pin,
    input wire logic i_sync_request_n,
    output logic [AMP_W-1:0] o_lane_drive_amplitude,
    output logic o_timing_reference,
    output logic o_sync_request,
    output logic o_low_rate_enable_first,
    output logic o_low_rate_enable_second,
    output logic o_low_rate_mode
);

    clcr_spi_if bus ();

    logic [AMP_W-1:0] lane_drive_amplitude;
    logic soft_reference_source;
    logic soft_reference_level;
    logic sync_request_invert;
    logic low_rate_enable_first;
    logic low_rate_enable_second;
    logic [7:0] page;
    logic [2:0] ref_s;
    logic [2:0] sync_s;
    logic ref_f;
    logic sync_f;

    clcr_spi_shifter u_shifter (
        .i_ref_clk(i_ref_clk),
        .i_rst_n(i_rst_n),
        .i_spi_sen_n(i_spi_sen_n),
        .i_spi_sclk(i_spi_sclk),
        .i_spi_sdin(i_spi_sdin),
        .o_spi_sdout(o_spi_sdout),
        .o_spi_sdout_oe(o_spi_sdout_oe),
        .bus(bus.shifter)
    );

    // Address hit in a given page; the page select register answers in every page
    function automatic logic reg_hit(input logic [ADDR_W-1:0] addr, input logic mpage,
                                     input logic [7:0] cur_page, input logic [7:0] want_page,
                                     input logic [ADDR_W-1:0] ofs);
        reg_hit = !mpage && cur_page == want_page && addr == ofs;
    endfunction

    logic wr_master;
    logic wr_conv;
    assign wr_master = bus.wr_strobe && reg_hit(bus.addr, bus.mpage, page, PAGE_MASTER, bus.addr);
    assign wr_conv = bus.wr_strobe && reg_hit(bus.addr, bus.mpage, page, PAGE_CONV, bus.addr);

    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            page <= RST_PAGE;
        end else if (bus.wr_strobe && !bus.mpage && bus.addr == OFS_PAGE_SEL) begin
            page <= bus.wdata;
        end
    end

    // Master page fields
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            lane_drive_amplitude <= RST_AMP;
            soft_reference_source <= 1'b0;
            soft_reference_level <= 1'b0;
            sync_request_invert <= 1'b0;
        end else if (wr_master) begin
            if (bus.addr == OFS_LANE_AMP) begin
                lane_drive_amplitude <= bus.wdata[AMP_LSB +: AMP_W];
            end
            if (bus.addr == OFS_SOFT_REF) begin
                soft_reference_source <= bus.wdata[REF_SRC_BIT];
                soft_reference_level <= bus.wdata[REF_LVL_BIT];
            end
            if (bus.addr == OFS_SYNC_POL) begin
                sync_request_invert <= bus.wdata[SYNC_INV_BIT];
            end
        end
    end

    // Converter page fields
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            low_rate_enable_first <= 1'b0;
            low_rate_enable_second <= 1'b0;
        end else if (wr_conv) begin
            if (bus.addr == OFS_LOW_RATE_1) begin
                low_rate_enable_first <= bus.wdata[LOW1_BIT];
            end
            if (bus.addr == OFS_LOW_RATE_2) begin
                low_rate_enable_second <= bus.wdata[LOW2_BIT];
            end
        end
    end

    // Read data; unused and write-only bits read zero
    always_comb begin
        bus.rdata = RST_BYTE;
        if (!bus.mpage && bus.addr == OFS_PAGE_SEL) begin
            bus.rdata = page;
        end else if (reg_hit(bus.addr, bus.mpage, page, PAGE_MASTER, OFS_LANE_AMP)) begin
            bus.rdata[AMP_LSB +: AMP_W] = lane_drive_amplitude;
        end else if (reg_hit(bus.addr, bus.mpage, page, PAGE_MASTER, OFS_SOFT_REF)) begin
            bus.rdata[REF_SRC_BIT] = soft_reference_source;
            bus.rdata[REF_LVL_BIT] = soft_reference_level;
        end else if (reg_hit(bus.addr, bus.mpage, page, PAGE_MASTER, OFS_SYNC_POL)) begin
            bus.rdata[SYNC_INV_BIT] = sync_request_invert;
        end else if (reg_hit(bus.addr, bus.mpage, page, PAGE_CONV, OFS_LOW_RATE_1)) begin
            bus.rdata[LOW1_BIT] = low_rate_enable_first;
        end else if (reg_hit(bus.addr, bus.mpage, page, PAGE_CONV, OFS_LOW_RATE_2)) begin
            bus.rdata[LOW2_BIT] = low_rate_enable_second;
        end
    end

    // Pin synchronisers
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ref_s <= 3'h0;
            sync_s <= 3'h7;
            ref_f <= 1'b0;
            sync_f <= 1'b1;
        end else begin
            ref_s <= {ref_s[1:0], i_timing_reference_pin};
            sync_s <= {sync_s[1:0], i_sync_request_n};
            if (ref_s[1] == ref_s[2]) begin
                ref_f <= ref_s[2];
            end
            if (sync_s[1] == sync_s[2]) begin
                sync_f <= sync_s[2];
            end
        end
    end

    // Timing reference and sync request paths
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_timing_reference <= 1'b0;
            o_sync_request <= 1'b0;
        end else begin
            o_timing_reference <= soft_reference_source ? soft_reference_level : ref_f;
            o_sync_request <= !sync_f ^ sync_request_invert;
        end
    end

    assign o_lane_drive_amplitude = lane_drive_amplitude;
    assign o_low_rate_enable_first = low_rate_enable_first;
    assign o_low_rate_enable_second = low_rate_enable_second;
    assign o_low_rate_mode = low_rate_enable_first && low_rate_enable_second;

    a_amp_write_lands: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        (wr_master && bus.addr == OFS_LANE_AMP) |=> o_lane_drive_amplitude == $past(bus.wdata[AMP_LSB +: AMP_W]))
        else $error("lane amplitude did not take the written code");

    a_ref_pin_path: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        !soft_reference_source |=> o_timing_reference == $past(ref_f))
        else $error("timing reference did not follow the pin");

    a_ref_soft_level: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        soft_reference_source [*2] |-> o_timing_reference == $past(soft_reference_level))
        else $error("timing reference did not follow the register level");

    a_sync_inv_flip: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        ($changed(sync_request_invert) && $stable(sync_f)) |=> $changed(o_sync_request))
        else $error("sync request did not flip with the invert bit");

    a_low_rate_both: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        (wr_conv && bus.addr == OFS_LOW_RATE_2 && bus.wdata[LOW2_BIT] && low_rate_enable_first)
        |=> o_low_rate_mode ##1 o_low_rate_mode || bus.wr_strobe)
        else $error("low rate mode not reached with both enables set");

    a_reset_zero: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        $rose(i_rst_n) |-> o_lane_drive_amplitude == 3'h0 && !soft_reference_source
            && !soft_reference_level && !sync_request_invert && !o_low_rate_mode && !o_timing_reference)
        else $error("fields not zero after reset");

    a_page_gate: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        (bus.wr_strobe && bus.addr == OFS_LOW_RATE_1 && (bus.mpage || page != PAGE_CONV))
        |=> $stable(low_rate_enable_first))
        else $error("low rate enable written outside the converter page");

    a_reserved_zero: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        (bus.hdr_done && bus.rw && reg_hit(bus.addr, bus.mpage, page, PAGE_MASTER, OFS_SYNC_POL))
        |=> bus.rdata == {2'h0, sync_request_invert, 5'h00})
        else $error("sync polarity read back wrong");

endmodule

// ---- clcr_regs_bench.sv ----
// Purpose: Self-checking bench for the link configuration register bank over the serial port.
// Assumes: Serial half period of 8 reference cycles; inputs change on the falling clock edge.
// Notes: Expected values come from field positions and page codes only.
`timescale 1ns/1ns
`define CHK(got, exp) begin checks++; if ((got) !== (exp)) begin n_mismatch++; \
    $display("MISMATCH at %0t: got %0h expected %0h", $time, (got), (exp)); end end
module clcr_regs_bench;
    import clcr_pkg::*;
    logic i_ref_clk = 1'b0;
    logic i_rst_n = 1'b0;
    logic i_spi_sen_n = 1'b1;
    logic i_spi_sclk = 1'b0;
    logic i_spi_sdin = 1'b0;
    logic i_timing_reference_pin = 1'b0;
    logic i_sync_request_n = 1'b1;
    logic o_spi_sdout;
    logic o_spi_sdout_oe;
    logic [AMP_W-1:0] o_lane_drive_amplitude;
    logic o_timing_reference;
    logic o_sync_request;
    logic o_low_rate_enable_first;
    logic o_low_rate_enable_second;
    logic o_low_rate_mode;
    int n_mismatch = 0;
    int checks = 0;

    clcr_regs clcr_regs_i (
        .i_ref_clk(i_ref_clk),
        .i_rst_n(i_rst_n),
        .i_spi_sen_n(i_spi_sen_n),
        .i_spi_sclk(i_spi_sclk),
        .i_spi_sdin(i_spi_sdin),
        .o_spi_sdout(o_spi_sdout),
        .o_spi_sdout_oe(o_spi_sdout_oe),
        .i_timing_reference_pin(i_timing_reference_pin),
        .i_sync_request_n(i_sync_request_n),
        .o_lane_drive_amplitude(o_lane_drive_amplitude),
        .o_timing_reference(o_timing_reference),
        .o_sync_request(o_sync_request),
        .o_low_rate_enable_first(o_low_rate_enable_first),
        .o_low_rate_enable_second(o_low_rate_enable_second),
        .o_low_rate_mode(o_low_rate_mode)
    );

    always #5 i_ref_clk = ~i_ref_clk;

    task automatic close_out();
        $display("Comparisons: %0d, mismatches: %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // One frame, MSB first; a short bit count aborts the frame
    task automatic spi(input logic [23:0] f, input int nbits, output logic [7:0] d);
        d = 8'h00;
        @(negedge i_ref_clk);
        i_spi_sen_n = 1'b0;
        repeat (4) @(negedge i_ref_clk);
        for (int i = 23; i >= 24 - nbits; i--) begin
            i_spi_sclk = 1'b0;
            i_spi_sdin = f[i];
            repeat (8) @(negedge i_ref_clk);
            if (f[23] && i < 8) begin
                d[i] = o_spi_sdout;
                `CHK(o_spi_sdout_oe, 1'b1)
            end
            i_spi_sclk = 1'b1;
            repeat (8) @(negedge i_ref_clk);
        end
        i_spi_sclk = 1'b0;
        repeat (8) @(negedge i_ref_clk);
        i_spi_sen_n = 1'b1;
        repeat (8) @(negedge i_ref_clk);
    endtask

    task automatic wr(input logic [11:0] a, input logic [7:0] v, input logic m = 1'b0);
        logic [7:0] x;
        spi({1'b0, m, 2'h0, a, v}, 24, x);
    endtask

    task automatic rd(input logic [11:0] a, output logic [7:0] v, input logic m = 1'b0);
        spi({1'b1, m, 2'h0, a, 8'h00}, 24, v);
    endtask

    task automatic do_reset();
        @(negedge i_ref_clk);
        i_rst_n = 1'b0;
        repeat (20) @(negedge i_ref_clk);
        i_rst_n = 1'b1;
        repeat (2) @(negedge i_ref_clk);
    endtask

    // Every field and output is zero after reset, in both pages
    task automatic t_reset_vals();
        logic [7:0] v;
        `CHK({o_lane_drive_amplitude, o_timing_reference, o_sync_request}, 5'h00)
        `CHK({o_low_rate_enable_first, o_low_rate_enable_second, o_low_rate_mode}, 3'h0)
        rd(OFS_LANE_AMP, v);
        `CHK(v, 8'h00)
        rd(OFS_SOFT_REF, v);
        `CHK(v, 8'h00)
        rd(OFS_SYNC_POL, v);
        `CHK(v, 8'h00)
        wr(OFS_PAGE_SEL, PAGE_CONV);
        rd(OFS_LOW_RATE_1, v);
        `CHK(v, 8'h00)
        rd(OFS_LOW_RATE_2, v);
        `CHK(v, 8'h00)
        wr(OFS_PAGE_SEL, PAGE_MASTER);
    endtask

    // All eight amplitude codes, with unused bits set high
    task automatic t_amp();
        logic [7:0] v;
        for (int c = 0; c < 8; c++) begin
            wr(OFS_LANE_AMP, 8'hf8 | 8'(c));
            `CHK(o_lane_drive_amplitude, 3'(c))
            rd(OFS_LANE_AMP, v);
            `CHK(v, 8'(c))
        end
        spi({1'b0, 1'b0, 2'h0, OFS_LANE_AMP, 8'h02}, 16, v);
        `CHK(o_lane_drive_amplitude, 3'h7)
    endtask

    // Pin source, then source select, then level
    task automatic t_ref();
        logic [7:0] v;
        i_timing_reference_pin = 1'b1;
        repeat (8) @(negedge i_ref_clk);
        `CHK(o_timing_reference, 1'b1)
        wr(OFS_SOFT_REF, 8'h08);
        `CHK(o_timing_reference, 1'b0)
        i_timing_reference_pin = 1'b0;
        wr(OFS_SOFT_REF, 8'h18);
        `CHK(o_timing_reference, 1'b1)
        rd(OFS_SOFT_REF, v);
        `CHK(v, 8'h18)
        wr(OFS_SOFT_REF, 8'h10);
        i_timing_reference_pin = 1'b1;
        repeat (8) @(negedge i_ref_clk);
        `CHK(o_timing_reference, 1'b1)
        i_timing_reference_pin = 1'b0;
        repeat (8) @(negedge i_ref_clk);
        `CHK(o_timing_reference, 1'b0)
    endtask

    task automatic t_sync();
        logic [7:0] v;
        i_sync_request_n = 1'b0;
        repeat (8) @(negedge i_ref_clk);
        `CHK(o_sync_request, 1'b1)
        wr(OFS_SYNC_POL, 8'hff);
        `CHK(o_sync_request, 1'b0)
        i_sync_request_n = 1'b1;
        repeat (8) @(negedge i_ref_clk);
        `CHK(o_sync_request, 1'b1)
        rd(OFS_SYNC_POL, v);
        `CHK(v, 8'h20)
    endtask

    // Low-rate bits exist only in the converter page
    task automatic t_page();
        logic [7:0] v;
        wr(OFS_LOW_RATE_1, 8'h04);
        `CHK(o_low_rate_enable_first, 1'b0)
        wr(OFS_PAGE_SEL, PAGE_CONV);
        wr(OFS_LOW_RATE_1, 8'hff);
        `CHK({o_low_rate_enable_first, o_low_rate_mode}, 2'b10)
        wr(OFS_LOW_RATE_2, 8'h10);
        `CHK({o_low_rate_enable_second, o_low_rate_mode}, 2'b11)
        rd(OFS_LOW_RATE_1, v);
        `CHK(v, 8'h04)
        rd(OFS_LANE_AMP, v);
        `CHK(v, 8'h00)
        wr(OFS_LOW_RATE_2, 8'h00, 1'b1);
        `CHK(o_low_rate_enable_second, 1'b1)
        rd(OFS_LOW_RATE_2, v, 1'b1);
        `CHK(v, 8'h00)
        wr(OFS_PAGE_SEL, PAGE_MASTER);
        rd(OFS_LANE_AMP, v);
        `CHK(v, 8'h07)
    endtask

    initial begin
        repeat (100000) @(posedge i_ref_clk);
        n_mismatch++;
        close_out();
    end

    initial begin
        do_reset();
        t_reset_vals();
        t_amp();
        t_ref();
        t_sync();
        t_page();
        do_reset();
        t_reset_vals();
        close_out();
    end
endmodule
